// *** pcs_phase_gen.sv ***
/*
 * pcs_phase_gen: divides the clock into four one-hot phase enables and counts start-up.
 * assumes clk and active-low asynchronous nrst; start pulses restart the wait.
 */
`timescale 1ns/1ps
module pcs_phase_gen (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       start,
	output logic [3:0]      phase,
	output logic            running
);
	import pcs_pkg::*;

	logic [1:0]  cnt;      // phase counter
	logic [10:0] waitCnt;  // start-up counter
	logic        waiting;  // start-up in progress

	////////////////////////////////////////////////////////////////////////
	// phase counter, frozen during start-up so cycles begin at phase 0
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt   <= 2'h0;
			phase <= 4'h0;
		end else if (waiting || start) begin
			cnt   <= 2'h0;
			phase <= 4'h0;
		end else begin
			cnt   <= cnt + 2'h1;                      // see (RULE1)
			phase <= 4'h1 << cnt;                     // see (RULE2)
		end
	end

	////////////////////////////////////////////////////////////////////////
	// start-up timer after reset or wake
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			waitCnt <= 11'h000;
			waiting <= 1'b1;
		end else if (start) begin
			waitCnt <= 11'h000;
			waiting <= 1'b1;
		end else if (waiting) begin
			waitCnt <= waitCnt + 11'h001;
			if (waitCnt == 11'(STARTUP_CYCLES - 1))
				waiting <= 1'b0;                      // see (RULE12)
		end
	end

	assign running = !waiting;

	property p_onehot;
		@(posedge clk) disable iff (!nrst) running |-> $onehot0(phase);
	endproperty
	a_onehot: assert property (p_onehot) else $error("phases overlap"); // see (RULE2)

	property p_wait;
		@(posedge clk) disable iff (!nrst) $rose(start) |=> !running [*8];
	endproperty
	a_wait: assert property (p_wait) else $error("start-up wait too short"); // see (RULE12)
endmodule : pcs_phase_gen

// *** pcs_pkg.sv ***
/*
 * pcs_pkg: constants, types and register map of the program counter sequencer.
 * assumes a single 40 MHz clock, APB register access and a 14-bit word-addressed program memory.
 */
//
// Operation
// (RULE1) instruction cycle is four system clocks
// (RULE2) four non-overlapping phase enables per cycle
// (RULE3) fetch next word while executing current
// (RULE4) pointer-changing instructions take two cycles
// (RULE5) pointer is fourteen bits wide
// (RULE6) pointer advances by one after fetch
// (RULE7) taken skip: dummy cycle, pointer plus two
// (RULE8) low byte readable, writable, keeps high bits
// (RULE9) low byte write jump inserts dummy cycle
// (RULE10) jump/call: bits 12..0 plus bank bit
// (RULE11) return reloads all fourteen bits from stack
// (RULE12) start-up wait after power-up or wake
// (RULE13) non-sequential events load target address
// (RULE14) reset clears pointer to word zero
// (RULE15) external interrupts vector 0x004 and 0x008
// (RULE16) timer overflows vector 0x00c and 0x010
// (RULE17) serial 0x014, multi-function 0x018
// (RULE18) dummy cycle performs no updates
package pcs_pkg;
	localparam int PC_W            = 14;              // pointer width
	localparam int PHASES          = 4;               // clocks per instruction cycle
	localparam int CLK_HZ          = 40000000;        // system clock rate
	localparam int STARTUP_PERIODS = 1024;            // start-up wait in system periods
	localparam int STARTUP_CYCLES  = STARTUP_PERIODS; // one period equals one clk
	localparam int BANK_BIT_POS    = 5;               // bank select bit position
	// apb byte addresses
	localparam logic [7:0] ADDR_LOW   = 8'h00;        // pointer low byte
	localparam logic [7:0] ADDR_BANK  = 8'h04;        // bank select register
	localparam logic [7:0] ADDR_STAT  = 8'h08;        // full pointer and status
	localparam logic [7:0] ADDR_CTRL  = 8'h0c;        // control address, reads zero and ignores writes
	localparam logic [7:0] BANK_RST   = 8'h00;        // bank select reset value
	localparam logic [13:0] PC_RST    = 14'h0000;     // reset vector
	localparam logic [13:0] VEC_EXT_A = 14'h0004;     // first external interrupt
	localparam logic [13:0] VEC_EXT_B = 14'h0008;     // second external interrupt
	localparam logic [13:0] VEC_TMR0  = 14'h000c;     // timer 0 overflow
	localparam logic [13:0] VEC_TMR1  = 14'h0010;     // timer 1 overflow
	localparam logic [13:0] VEC_SER   = 14'h0014;     // serial port
	localparam logic [13:0] VEC_MULTI = 14'h0018;     // multi-function

	// sequencing operation requested by the decoder for the executing word
	typedef enum logic [2:0] {PCS_OP_NEXT, PCS_OP_SKIP, PCS_OP_JUMP, PCS_OP_CALL,
		PCS_OP_RET, PCS_OP_HALT} pcs_op_e;

	// decoder request, sampled at the end of each execute cycle
	typedef struct packed {
		pcs_op_e     op;       // operation
		logic        skipTake; // skip condition met
		logic [12:0] target;   // instruction code address bits
		logic [13:0] stackTop; // top of return stack
	} pcs_req_s;

	// interrupt acknowledges, one-hot
	typedef struct packed {
		logic extA;
		logic extB;
		logic tmr0;
		logic tmr1;
		logic ser;
		logic multi;
	} pcs_irq_s;
endpackage : pcs_pkg

// *** pcs_prog_mem.sv ***
/*
 * pcs_prog_mem: behavioural program memory facing the sequencer's fetch port.
 * assumes fetchEn is a one-clock pulse; each word carries its own address for tracing.
 */
`timescale 1ns/1ps
module pcs_prog_mem (
	input  wire logic        clk,       // system clock
	input  wire logic [13:0] fetchAddr, // word address
	input  wire logic        fetchEn,   // fetch pulse
	output logic      [15:0] fetchData  // word read
);
	////////////////////////////////////////////////////////////////////////////////
	// word answers one clock after the fetch and holds until the next fetch
	always_ff @(posedge clk) begin
		if (fetchEn) begin
			fetchData <= {2'b01, fetchAddr};
		end
	end
endmodule : pcs_prog_mem

// *** pcs_sequencer.sv ***
/*
 * pcs_sequencer: program counter sequencer with fetch/execute overlap and apb registers.
 * assumes program memory returns the word one clock after fetchAddr with fetchEn,
 * and a decoder that drives req during each execute cycle.
 */
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
module pcs_sequencer (
	input  wire logic              clk,
	input  wire logic              nrst,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// program memory
	output logic [13:0]            fetchAddr,
	output logic                   fetchEn,
	input  wire logic [15:0]       fetchData,
	// decoder
	input  wire pcs_pkg::pcs_req_s req,
	input  wire pcs_pkg::pcs_irq_s irqAck,
	input  wire logic              wake,
	output logic [15:0]            execWord,
	output logic                   execValid,
	output logic                   execStrobe,
	output logic                   pushEn,
	output logic [13:0]            pushAddr,
	output logic                   halted
);
	import pcs_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// state
	logic [13:0] instrPointer;    // program counter, fourteen bits: see (RULE5)
	logic [7:0]  bankSelectReg;   // bank select register
	logic        dummy;           // current execute cycle is a dummy
	logic [3:0]  phase;           // phase enables
	logic        running;         // start-up finished
	logic        startPulse;      // restart start-up timer
	logic        lowWrPend;       // low byte write awaits cycle end
	logic [7:0]  lowWrData;       // pending low byte

	////////////////////////////////////////////////////////////////////////
	// decode wires
	wire         bankSelectBit = bankSelectReg[BANK_BIT_POS];
	// startPulse masks the one clock between leaving halt and the timer restart
	wire         cycEnd    = phase[3] && running && !halted && !startPulse;
	wire         fetchPh   = phase[0] && running && !halted && !startPulse;
	wire         apbAcc    = psel && penable;
	wire         apbWr     = apbAcc && pwrite;
	wire         hitLow    = paddr == ADDR_LOW;
	wire         hitBank   = paddr == ADDR_BANK;
	wire         hitStat   = paddr == ADDR_STAT;
	wire         hitCtrl   = paddr == ADDR_CTRL;
	wire         hitAny    = hitLow || hitBank || hitStat || hitCtrl;
	wire         anyIrq    = |irqAck;
	wire         live      = !dummy;                      // see (RULE18)
	wire         skipGo    = live && req.op == PCS_OP_SKIP && req.skipTake;
	wire         jumpGo    = live && (req.op == PCS_OP_JUMP || req.op == PCS_OP_CALL);
	wire         retGo     = live && req.op == PCS_OP_RET;
	wire         haltGo    = live && req.op == PCS_OP_HALT;
	wire         lowGo     = lowWrPend;
	wire         redirect  = anyIrq || jumpGo || retGo || lowGo;
	wire [13:0]  execAddr  = instrPointer - 14'h2;                          // address of the executing word
	wire [13:0]  skipAddr  = {execAddr[13], execAddr[12:0] + 13'h2};        // see (RULE7)
	wire [13:0]  jumpAddr  = {bankSelectBit, req.target};                  // see (RULE10)
	wire [13:0]  lowAddr   = {instrPointer[13:8], lowWrData};              // see (RULE8)
	logic [13:0] irqVec;

	// vector select, first acknowledge wins
	always_comb begin
		irqVec = PC_RST;
		if (irqAck.extA)       irqVec = VEC_EXT_A;            // see (RULE15)
		else if (irqAck.extB)  irqVec = VEC_EXT_B;            // see (RULE15)
		else if (irqAck.tmr0)  irqVec = VEC_TMR0;             // see (RULE16)
		else if (irqAck.tmr1)  irqVec = VEC_TMR1;             // see (RULE16)
		else if (irqAck.ser)   irqVec = VEC_SER;              // see (RULE17)
		else if (irqAck.multi) irqVec = VEC_MULTI;            // see (RULE17)
	end

	// next pointer at cycle end; pointer already holds prefetch address + 1
	logic [13:0] next_instrPointer;
	always_comb begin
		if (anyIrq)       next_instrPointer = irqVec;          // see (RULE13)
		else if (lowGo)   next_instrPointer = lowAddr;         // see (RULE9)
		else if (retGo)   next_instrPointer = req.stackTop;    // see (RULE11)
		else if (jumpGo)  next_instrPointer = jumpAddr;        // see (RULE13)
		else if (skipGo)  next_instrPointer = skipAddr;        // see (RULE7)
		else              next_instrPointer = instrPointer;
	end

	pcs_phase_gen u_pcs_phase_gen (
		.clk     (clk),
		.nrst    (nrst),
		.start   (startPulse),
		.phase   (phase),
		.running (running)
	);

	////////////////////////////////////////////////////////////////////////
	// fetch: issue address in phase 0, bump pointer
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fetchAddr <= PC_RST;
			fetchEn   <= 1'b0;
		end else begin
			fetchEn <= fetchPh;
			if (fetchPh)
				fetchAddr <= instrPointer;                      // see (RULE3)
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pointer update
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			instrPointer <= PC_RST;                              // see (RULE14)
		else if (fetchPh)
			instrPointer <= instrPointer + 14'h1;                // see (RULE6)
		else if (cycEnd)
			instrPointer <= next_instrPointer;
	end

	////////////////////////////////////////////////////////////////////////
	// execute stage: latch prefetched word, flag discarded ones as dummy
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			execWord   <= 16'h0000;
			execValid  <= 1'b0;
			execStrobe <= 1'b0;
			dummy      <= 1'b1;
		end else begin
			execStrobe <= cycEnd;
			if (cycEnd) begin
				execWord  <= fetchData;
				dummy     <= redirect || skipGo;               // see (RULE4)
				execValid <= !(redirect || skipGo);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// return stack push for calls and interrupts
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pushEn   <= 1'b0;
			pushAddr <= PC_RST;
		end else begin
			pushEn <= cycEnd && (anyIrq || (jumpGo && req.op == PCS_OP_CALL));
			if (cycEnd)
				pushAddr <= instrPointer - 14'h1;                // word after the executing one
		end
	end

	////////////////////////////////////////////////////////////////////////
	// halt and wake
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			halted     <= 1'b0;
			startPulse <= 1'b0;
		end else begin
			startPulse <= halted && wake;                       // see (RULE12)
			if (halted && wake)
				halted <= 1'b0;
			else if (cycEnd && haltGo)
				halted <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// apb registers, zero wait states
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bankSelectReg <= BANK_RST;
			lowWrPend     <= 1'b0;
			lowWrData     <= 8'h00;
			prdata        <= 32'h0000_0000;
			pready        <= 1'b0;
			pslverr       <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !hitAny;
			if (apbWr && hitBank && pready)
				bankSelectReg <= pwdata[7:0];
			if (apbWr && hitLow && pready) begin
				lowWrPend <= 1'b1;                              // see (RULE8)
				lowWrData <= pwdata[7:0];
			end else if (cycEnd)
				lowWrPend <= 1'b0;
			if (psel && !penable) begin
				if (hitLow)       prdata <= {24'h0, instrPointer[7:0]};
				else if (hitBank) prdata <= {24'h0, bankSelectReg};
				else if (hitStat) prdata <= {16'h0, halted, running, instrPointer};
				else              prdata <= 32'h0000_0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_jump;
		cycEnd && jumpGo && !anyIrq && !lowGo && !retGo;
	endsequence
	property p_jump;
		@(posedge clk) disable iff (!nrst) s_jump |=>
			instrPointer == {$past(bankSelectReg[BANK_BIT_POS]), $past(req.target)};
	endproperty
	a_jump: assert property (p_jump) else $error("jump target wrong"); // see (RULE10)

	property p_dummy;
		@(posedge clk) disable iff (!nrst) (cycEnd && (redirect || skipGo)) |=> dummy && !execValid;
	endproperty
	a_dummy: assert property (p_dummy) else $error("no dummy cycle"); // see (RULE4)

	property p_inc;
		@(posedge clk) disable iff (!nrst) fetchPh |=> instrPointer == $past(instrPointer) + 14'h1;
	endproperty
	a_inc: assert property (p_inc) else $error("pointer not advanced"); // see (RULE6)

	property p_cycle;
		@(posedge clk) disable iff (!nrst) (cycEnd && !wake) |=> !cycEnd [*3];
	endproperty
	a_cycle: assert property (p_cycle) else $error("cycle shorter than four clocks"); // see (RULE1)

	property p_bank;
		@(posedge clk) disable iff (!nrst) (cycEnd && lowGo && !anyIrq) |=>
			instrPointer[13:8] == $past(instrPointer[13:8]);
	endproperty
	a_bank: assert property (p_bank) else $error("low byte write changed page"); // see (RULE8)

	property p_vec;
		@(posedge clk) disable iff (!nrst) (cycEnd && irqAck.extA) |=> instrPointer == VEC_EXT_A;
	endproperty
	a_vec: assert property (p_vec) else $error("bad interrupt vector"); // see (RULE15)

	property p_skipbank;
		@(posedge clk) disable iff (!nrst) (cycEnd && skipGo && !redirect) |=>
			instrPointer[13] == $past(execAddr[13]);
	endproperty
	a_skipbank: assert property (p_skipbank) else $error("skip left bank"); // see (RULE7)

	property p_quiet;
		@(posedge clk) disable iff (!nrst) (dummy && cycEnd && !anyIrq && !lowGo) |=>
			instrPointer == $past(instrPointer);
	endproperty
	a_quiet: assert property (p_quiet) else $error("dummy cycle changed pointer"); // see (RULE18)
endmodule : pcs_sequencer

// *** test_program_counter_sequencer.sv ***
/*
 * test_program_counter_sequencer: apb and decoder driven checks of the sequencer.
 * assumes pcs_pkg, pcs_sequencer and the pcs_prog_mem model; bench acts as decoder.
 */
`timescale 1ns/1ps
module test_program_counter_sequencer;
	import pcs_pkg::*;
	logic clk, nrst, psel, penable, pwrite, pready, pslverr, fetchEn, wake;
	logic execValid, execStrobe, pushEn, halted, e, pushSeen;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic [13:0] fetchAddr, pushAddr, cur, pushVal;
	logic [15:0] fetchData, execWord, a;
	pcs_req_s    req;
	pcs_irq_s    irqAck;
	int          errorCnt, cmpCount, gap, cyc, rel, n;
	logic [13:0] vec [6] = '{VEC_EXT_A, VEC_EXT_B, VEC_TMR0, VEC_TMR1, VEC_SER, VEC_MULTI};

	pcs_sequencer u_pcs_sequencer (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fetchAddr(fetchAddr), .fetchEn(fetchEn), .fetchData(fetchData),
		.req(req), .irqAck(irqAck), .wake(wake), .execWord(execWord), .execValid(execValid),
		.execStrobe(execStrobe), .pushEn(pushEn), .pushAddr(pushAddr), .halted(halted));
	pcs_prog_mem u_pcs_prog_mem (.clk(clk), .fetchAddr(fetchAddr), .fetchEn(fetchEn),
		.fetchData(fetchData));

	////////////////////////////////////////////////////////////////////////////////
	// clock, cycle count and return-address capture
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (pushEn === 1'b1) begin
			pushSeen <= 1;
			pushVal  <= pushAddr;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// compare, verdict and waits
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp) begin
			errorCnt++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task endSim;
		$display("compares %0d mismatches %0d", cmpCount, errorCnt);
		if (errorCnt == 0 && cmpCount > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : endSim
	// wait for the next new executing word, counting clocks
	task ws;
		gap = 0;
		do begin
			@(posedge clk);
			gap++;
		end while (execStrobe !== 1'b1 && gap < 3000);
		if (gap >= 3000) begin
			errorCnt++;
			$display("ERROR %0t no new word", $time);
		end
	endtask : ws
	// one apb transfer, entered on a clock edge
	task apb(input logic [7:0] ad, input logic w, input logic [31:0] d);
		psel <= 1; penable <= 0; paddr <= ad; pwrite <= w; pwdata <= d;
		@(posedge clk);
		penable <= 1;
		// no assumed wait count: only the watchdog ends a stuck transfer
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask : apb
	// decoder request for the word now executing
	task go(input pcs_op_e op, input logic sk, input logic [12:0] tg, input logic [13:0] st,
		input pcs_irq_s ir);
		req <= '{op: op, skipTake: sk, target: tg, stackTop: st};
		irqAck <= ir;
	endtask : go
	// next word dummy, then the word at address t
	task land(input logic [13:0] t);
		ws();
		req <= '0;
		irqAck <= '0;
		chk(execValid, 0);
		ws();
		chk(execValid, 1);
		chk(execWord, {2'b01, t});
	endtask : land

	////////////////////////////////////////////////////////////////////////////////
	// watchdog
	initial begin
		#(25 * 20000);
		errorCnt++;
		$display("ERROR %0t watchdog expired", $time);
		endSim();
	end

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		nrst = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0; wake = 0;
		req = '0; irqAck = '0; cyc = 0; errorCnt = 0; cmpCount = 0; pushSeen = 0;
		repeat (5) @(posedge clk);
		nrst <= 1;
		rel = cyc;
		apb(ADDR_STAT, 0, 0); chk(r, 0); chk(e, 0);
		apb(ADDR_LOW, 0, 0); chk(r, 0);
		apb(ADDR_BANK, 0, 0); chk(r, {24'h0, BANK_RST});
		apb(ADDR_CTRL, 0, 0); chk(r, 0);
		apb(8'h10, 0, 0); chk(e, 1);
		ws(); chk(cyc - rel >= STARTUP_CYCLES, 1);
		$display("test reset finished");
		ws();
		for (int i = 0; i < 6; i++) begin
			a = execWord;
			ws(); chk(gap, PHASES);
			chk(execValid, 1); chk(execWord, a + 16'h1);
		end
		cur = execWord[13:0];
		go(PCS_OP_SKIP, 0, '0, '0, '0);
		ws(); req <= '0; chk(execWord, {2'b01, cur + 14'h1});
		cur = execWord[13:0];
		go(PCS_OP_SKIP, 1, '0, '0, '0); land(cur + 14'h2);
		$display("test sequence finished");
		apb(ADDR_BANK, 1, 32'h20); ws();
		go(PCS_OP_JUMP, 0, 13'h0100, '0, '0); land(14'h2100);
		apb(ADDR_BANK, 1, 0); ws();
		cur = execWord[13:0]; pushSeen = 0;
		go(PCS_OP_CALL, 0, 13'h0040, '0, '0); land(14'h0040);
		chk(pushSeen, 1); chk(pushVal, cur + 14'h1);
		go(PCS_OP_RET, 0, '0, 14'h3ff0, '0); land(14'h3ff0);
		ws(); cur = execWord[13:0];
		apb(ADDR_LOW, 1, 32'h55); land({cur[13:8], 8'h55});
		$display("test branch finished");
		for (int i = 0; i < 6; i++) begin
			pushSeen = 0;
			go(PCS_OP_NEXT, 0, '0, '0, pcs_irq_s'(6'b100000 >> i));
			land(vec[i]); chk(pushSeen, 1);
		end
		$display("test vector finished");
		go(PCS_OP_HALT, 0, '0, '0, '0);
		n = 0;
		while (halted !== 1'b1 && n < 16) begin
			@(posedge clk);
			n++;
		end
		req <= '0; chk(halted, 1);
		wake <= 1;
		rel = cyc;
		n = 0;
		while (halted !== 1'b0 && n < 16) begin
			@(posedge clk);
			n++;
		end
		wake <= 0;
		ws(); chk(cyc - rel >= STARTUP_CYCLES, 1);
		$display("test halt finished");
		endSim();
	end
endmodule : test_program_counter_sequencer
